// [rtl/adc_regs_pkg.sv]
package adc_regs_pkg;
  // Bus and result widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 24;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_CHECKSUM   = 4'h3;
  localparam logic [3:0] IDX_RESULT     = 4'h4;
  localparam logic [3:0] IDX_IFMODE     = 4'h8;
  localparam logic [3:0] IDX_STATUS     = 4'h9;
  localparam logic [3:0] IDX_USER0      = 4'hA;
  localparam logic [3:0] IDX_USER1      = 4'hB;
  localparam logic [3:0] IDX_INT_STATUS = 4'hC;
  localparam logic [3:0] IDX_INT_ENABLE = 4'hD;
  localparam logic [3:0] IDX_INT_CLEAR  = 4'hE;

  // Interface mode and user register field positions
  localparam int IFM_SHORT_WORD_BIT = 0;
  localparam int IFM_CRC_LSB        = 2;
  localparam int IFM_INTEGRITY_BIT  = 5;
  localparam int IFM_APPEND_BIT     = 6;
  localparam int USER_POLARITY_BIT  = 0;

  // Interrupt bit positions
  localparam int INT_W             = 2;
  localparam int INT_RESULT_BIT    = 0;
  localparam int INT_INTEGRITY_BIT = 1;

  // Reset values
  localparam logic [6:0]       IFMODE_RST   = 7'h00;
  localparam logic [RES_W-1:0] CHECKSUM_RST = 24'h00_0000;
  localparam logic [RES_W-1:0] RESULT_RST   = 24'h00_0000;
  localparam logic [RES_W-1:0] USER_RST     = 24'h00_0000;
  localparam logic [7:0]       STATUS_RST   = 8'h80;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Checksum protection modes
  typedef enum logic [1:0] {
    CRC_OFF      = 2'b00,
    CRC_XOR_READ = 2'b01,
    CRC_FULL     = 2'b10,
    CRC_ILLEGAL  = 2'b11
  } crc_mode_t;

  typedef struct packed {
    logic      status_append;
    logic      integrity_en;
    logic      rsvd4;
    crc_mode_t crc_mode;
    logic      rsvd1;
    logic      short_word_select;
  } ifmode_t;

  typedef struct packed {
    logic       ready_n;
    logic [1:0] rsvd;
    logic       integrity_error;
    logic [3:0] channel;
  } status_t;

  typedef struct packed {
    logic extra_byte;
    logic read_xor;
    logic read_crc;
    logic write_crc;
  } link_prot_t;
endpackage

// [rtl/adc_result_and_checksum_regs.sv]
`timescale 1ns/1ps
module adc_result_and_checksum_regs (
  // Clock and reset
  input  wire logic                              mclk_in,
  input  wire logic                              rst_n_in,
  // AXI4-Lite write channels
  input  wire logic [adc_regs_pkg::ADDR_W-1:0]   s_axi_awaddr_in,
  input  wire logic                              s_axi_awvalid_in,
  output logic                                   s_axi_awready_out,
  input  wire logic [adc_regs_pkg::DATA_W-1:0]   s_axi_wdata_in,
  input  wire logic [3:0]                        s_axi_wstrb_in,
  input  wire logic                              s_axi_wvalid_in,
  output logic                                   s_axi_wready_out,
  output logic [1:0]                             s_axi_bresp_out,
  output logic                                   s_axi_bvalid_out,
  input  wire logic                              s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [adc_regs_pkg::ADDR_W-1:0]   s_axi_araddr_in,
  input  wire logic                              s_axi_arvalid_in,
  output logic                                   s_axi_arready_out,
  output logic [adc_regs_pkg::DATA_W-1:0]        s_axi_rdata_out,
  output logic [1:0]                             s_axi_rresp_out,
  output logic                                   s_axi_rvalid_out,
  input  wire logic                              s_axi_rready_in,
  // Converter core
  input  wire logic                              conv_valid_in,
  input  wire logic [adc_regs_pkg::RES_W-1:0]    conv_data_in,
  input  wire logic [3:0]                        conv_channel_in,
  // Device outputs
  output logic                                   rdy_n_out,
  output logic                                   irq_out,
  output adc_regs_pkg::link_prot_t               link_prot_out
);
  import adc_regs_pkg::*;

  ifmode_t          ifmode_reg;
  status_t          status_reg;
  logic             ready_n_reg;
  logic             integrity_error_reg;
  logic [3:0]       channel_reg;
  logic [RES_W-1:0] user_reg [2];
  logic [RES_W-1:0] checksum_reg;
  logic [RES_W-1:0] result_reg;
  logic             result_short_reg;
  logic             result_lock_reg;
  logic [INT_W-1:0] int_status_reg;
  logic [INT_W-1:0] int_enable_reg;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [3:0]       wr_idx_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0]       wstrb_reg;

  // Register index from a byte address, or an out-of-range marker
  function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = (addr[ADDR_W-1:6] == '0) ? {1'b0, addr[5:2]} : 5'h10;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [RES_W-1:0] merge_strb(input logic [RES_W-1:0] old_val,
                                                   input logic [DATA_W-1:0] new_val,
                                                   input logic [3:0] strb);
    merge_strb = old_val;
    for (int b = 0; b < 3; b++) begin
      if (strb[b]) begin
        merge_strb[8*b +: 8] = new_val[8*b +: 8];
      end
    end
  endfunction

  // Coding and length of a fresh conversion result
  function automatic logic [RES_W-1:0] code_result(input logic [RES_W-1:0] raw,
                                                    input logic unipolar,
                                                    input logic short_word);
    logic [RES_W-1:0] coded;
    coded = unipolar ? raw : {~raw[RES_W-1], raw[RES_W-2:0]};
    code_result = short_word ? {8'h00, coded[RES_W-1:8]} : coded;
  endfunction

  // Bus handshake terms
  logic       wr_fire;
  logic       ar_fire;
  logic [4:0] ar_idx;
  logic       rd_result_take;
  logic       capture;
  logic       user_wr;
  logic [RES_W-1:0] user_new;
  logic       user_changed;

  assign wr_fire        = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  assign ar_fire        = s_axi_arvalid_in && s_axi_arready_out;
  assign status_reg     = '{ready_n_reg, STATUS_RST[6:5], integrity_error_reg, channel_reg};
  assign ar_idx         = reg_index(s_axi_araddr_in);
  assign rd_result_take = ar_fire && (ar_idx == {1'b0, IDX_RESULT});
  assign capture        = conv_valid_in && !result_lock_reg && !rd_result_take;
  assign user_wr        = wr_fire && (wr_idx_reg == IDX_USER0 || wr_idx_reg == IDX_USER1);
  assign user_new       = merge_strb(user_reg[wr_idx_reg[0] ? 1 : 0], wdata_reg, wstrb_reg);
  assign user_changed   = user_wr && (user_new != user_reg[wr_idx_reg[0] ? 1 : 0]);

  // Write address and data capture, in either order
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      wr_idx_reg        <= 4'h0;
      wdata_reg         <= '0;
      wstrb_reg         <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg       <= 1'b1;
        s_axi_awready_out <= 1'b0;
        wr_idx_reg        <= reg_index(s_axi_awaddr_in) > 5'h0F ?
                             4'h0 : s_axi_awaddr_in[5:2];
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg       <= 1'b1;
        s_axi_wready_out <= 1'b0;
        wdata_reg        <= s_axi_wdata_in;
        wstrb_reg        <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Write response; read-only and unmapped words answer with an error
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_out <= 1'b1;
      unique case (wr_idx_reg)
        IDX_IFMODE, IDX_USER0, IDX_USER1, IDX_INT_ENABLE, IDX_INT_CLEAR: begin
          s_axi_bresp_out <= RESP_OKAY;
        end
        default: begin
          s_axi_bresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Interface mode register; the converter keeps running across writes
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ifmode_reg <= ifmode_t'(IFMODE_RST);
    end else if (wr_fire && wr_idx_reg == IDX_IFMODE && wstrb_reg[0]) begin
      ifmode_reg.short_word_select <= wdata_reg[IFM_SHORT_WORD_BIT];
      ifmode_reg.crc_mode          <= crc_mode_t'(wdata_reg[IFM_CRC_LSB +: 2]);
      ifmode_reg.integrity_en      <= wdata_reg[IFM_INTEGRITY_BIT];
      ifmode_reg.status_append     <= wdata_reg[IFM_APPEND_BIT];
      ifmode_reg.rsvd4             <= 1'b0;
      ifmode_reg.rsvd1             <= 1'b0;
    end
  end

  // Checked user registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      user_reg[0] <= USER_RST;
      user_reg[1] <= USER_RST;
    end else if (user_wr) begin
      user_reg[wr_idx_reg[0] ? 1 : 0] <= user_new;
    end
  end

  // Checksum over user registers only, zero while the check is off
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      checksum_reg <= CHECKSUM_RST;
    end else begin
      checksum_reg <= ifmode_reg.integrity_en ? (user_reg[0] ^ user_reg[1]) : '0;
    end
  end

  // Integrity error flag; clearing the enable clears it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      integrity_error_reg <= STATUS_RST[4];
    end else if (user_changed && ifmode_reg.integrity_en) begin
      integrity_error_reg <= 1'b1;
    end else if (!ifmode_reg.integrity_en ||
                 (wr_fire && wr_idx_reg == IDX_IFMODE && wstrb_reg[0] &&
                  !wdata_reg[IFM_INTEGRITY_BIT])) begin
      integrity_error_reg <= 1'b0;
    end
  end

  // Conversion result capture and the ready flag
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_reg         <= RESULT_RST;
      result_short_reg   <= 1'b0;
      ready_n_reg        <= STATUS_RST[7];
      channel_reg        <= STATUS_RST[3:0];
    end else if (capture) begin
      result_reg         <= code_result(conv_data_in, user_reg[0][USER_POLARITY_BIT],
                                        ifmode_reg.short_word_select);
      result_short_reg   <= ifmode_reg.short_word_select;
      ready_n_reg        <= 1'b0;
      channel_reg        <= conv_channel_in;
    end else if (rd_result_take) begin
      ready_n_reg        <= 1'b1;
    end
  end

  // Read lock from result command until its data is taken
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_lock_reg <= 1'b0;
    end else if (rd_result_take) begin
      result_lock_reg <= 1'b1;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      result_lock_reg <= 1'b0;
    end
  end

  // Read data selection
  logic [DATA_W-1:0] rd_data;
  logic [1:0]        rd_resp;
  logic [RES_W-1:0]  result_view;

  always_comb begin
    result_view = result_short_reg ? {8'h00, result_reg[15:0]} : result_reg;
    rd_data     = '0;
    rd_resp     = RESP_OKAY;
    unique case (ar_idx)
      {1'b0, IDX_CHECKSUM}: rd_data = {8'h00, checksum_reg};
      {1'b0, IDX_RESULT}: begin
        if (ifmode_reg.status_append) begin
          rd_data = result_short_reg ? {8'h00, result_view[15:0], status_reg}
                                     : {result_view, status_reg};
        end else begin
          rd_data = {8'h00, result_view};
        end
      end
      {1'b0, IDX_IFMODE}:     rd_data = {25'h000_0000, ifmode_reg};
      {1'b0, IDX_STATUS}:     rd_data = {24'h00_0000, status_reg};
      {1'b0, IDX_USER0}:      rd_data = {8'h00, user_reg[0]};
      {1'b0, IDX_USER1}:      rd_data = {8'h00, user_reg[1]};
      {1'b0, IDX_INT_STATUS}: rd_data = {30'h0000_0000, int_status_reg};
      {1'b0, IDX_INT_ENABLE}: rd_data = {30'h0000_0000, int_enable_reg};
      default:                rd_resp = RESP_SLVERR;
    endcase
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= '0;
      s_axi_rresp_out   <= RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_data;
      s_axi_rresp_out   <= rd_resp;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
    end
  end

  // Interrupt status, enable and write-one-to-clear; a set wins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      int_status_reg <= '0;
      int_enable_reg <= '0;
      irq_out        <= 1'b0;
    end else begin
      for (int i = 0; i < INT_W; i++) begin
        if ((i == INT_RESULT_BIT && capture) ||
            (i == INT_INTEGRITY_BIT && user_changed && ifmode_reg.integrity_en)) begin
          int_status_reg[i] <= 1'b1;
        end else if (wr_fire && wr_idx_reg == IDX_INT_CLEAR && wstrb_reg[0] && wdata_reg[i]) begin
          int_status_reg[i] <= 1'b0;
        end
      end
      if (wr_fire && wr_idx_reg == IDX_INT_ENABLE && wstrb_reg[0]) begin
        int_enable_reg <= wdata_reg[INT_W-1:0];
      end
      irq_out <= |(int_status_reg & int_enable_reg);
    end
  end

  // Ready pin and link protection outputs
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_n_out     <= STATUS_RST[7];
      link_prot_out <= '0;
    end else begin
      rdy_n_out <= status_reg.ready_n;
      unique case (ifmode_reg.crc_mode)
        CRC_XOR_READ: link_prot_out <= '{1'b1, 1'b1, 1'b0, 1'b1};
        CRC_FULL:     link_prot_out <= '{1'b1, 1'b0, 1'b1, 1'b1};
        CRC_OFF:      link_prot_out <= '0;
        CRC_ILLEGAL:  link_prot_out <= '0;
      endcase
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_result_cmd;
    rd_result_take;
  endsequence

  sequence seq_answer;
    ##1 s_axi_rvalid_out;
  endsequence

  AST_RESERVED_ZERO: assert property (
    ar_fire && ar_idx == {1'b0, IDX_IFMODE} |=> s_axi_rdata_out[4] == 1'b0 &&
      s_axi_rdata_out[1] == 1'b0)
    else $error("reserved mode bits read nonzero");

  AST_CHECKSUM_OFF: assert property (
    ar_fire && ar_idx == {1'b0, IDX_CHECKSUM} && !$past(ifmode_reg.integrity_en)
      |=> s_axi_rdata_out == '0)
    else $error("checksum read nonzero while disabled");

  AST_READY_FORCED: assert property (
    seq_result_cmd |-> seq_answer ##1 rdy_n_out)
    else $error("ready pin not forced high after result read");

  AST_RESULT_HELD: assert property (
    result_lock_reg && conv_valid_in |=> $stable(result_reg))
    else $error("result changed during pending read");

  AST_SHORT_WORD: assert property (
    capture && ifmode_reg.short_word_select |=> result_reg[23:16] == 8'h00 &&
      result_short_reg)
    else $error("short word result not reduced");

  AST_EXTRA_BYTE: assert property (
    ##1 link_prot_out.extra_byte == ($past(ifmode_reg.crc_mode) == CRC_XOR_READ ||
      $past(ifmode_reg.crc_mode) == CRC_FULL))
    else $error("extra byte flag wrong for mode");

  AST_READ_KIND: assert property (
    ##1 link_prot_out.read_xor == ($past(ifmode_reg.crc_mode) == CRC_XOR_READ) &&
      link_prot_out.write_crc == link_prot_out.extra_byte)
    else $error("read checksum kind wrong for mode");

  AST_APPEND_STATUS: assert property (
    seq_result_cmd ##0 ifmode_reg.status_append |-> seq_answer ##0
      s_axi_rdata_out[7:0] == $past(status_reg))
    else $error("status not appended to result");

  AST_INTEGRITY_SET: assert property (
    user_changed && ifmode_reg.integrity_en |=> status_reg.integrity_error [*2])
    else $error("integrity error not raised");

  AST_INTEGRITY_CLR: assert property (
    !ifmode_reg.integrity_en |=> !status_reg.integrity_error)
    else $error("integrity error kept while disabled");

  AST_NO_RESTART: assert property (
    wr_fire && wr_idx_reg == IDX_IFMODE && !conv_valid_in |=> $stable(result_reg))
    else $error("mode write disturbed result");
endmodule // adc_result_and_checksum_regs

// [verif/adc_result_and_checksum_regs_bench.sv]
`timescale 1ns/1ps
module adc_result_and_checksum_regs_bench;
  import adc_regs_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic conv_valid_in = 1'b0;
  logic [RES_W-1:0] conv_data_in = '0;
  logic [3:0] conv_channel_in = 4'h0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb, ch;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, rdy_n_out, irq_out, hung;
  logic [1:0] bresp, rresp, rr;
  logic [23:0] u0, u1, raw, held;
  link_prot_t link_prot_out;
  int num_errors = 0;
  int n_tests = 0;

  // Free running clock
  always #10 mclk_in = ~mclk_in;

  adc_result_and_checksum_regs adc_result_and_checksum_regs_i (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
    .conv_channel_in(conv_channel_in), .rdy_n_out(rdy_n_out), .irq_out(irq_out),
    .link_prot_out(link_prot_out));

  axil_host_model axil_host_model_i (
    .clk_in(mclk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
    .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
    .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
    .rvalid_in(rvalid), .rready_out(rready), .hung_out(hung));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // A stuck handshake ends the run
  always @(posedge hung) begin
    num_errors++;
    test_done();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axil_host_model_i.wr(a, d, rr);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axil_host_model_i.rd(a, 0, rv, rr);
    chk(rv, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  // One-cycle converter strobe, then let the ready pin settle
  task automatic conv(input logic [23:0] d, input logic [3:0] c);
    @(posedge mclk_in);
    conv_data_in <= d;
    conv_channel_in <= c;
    conv_valid_in <= 1'b1;
    @(posedge mclk_in);
    conv_valid_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  function automatic logic [23:0] code(input logic [23:0] d, input logic uni);
    return uni ? d : {~d[23], d[22:0]};
  endfunction

  function automatic logic [3:0] prot(input logic [1:0] m);
    return (m == 2'b01) ? 4'b1101 : ((m == 2'b10) ? 4'b1011 : 4'h0);
  endfunction

  initial begin
    void'($urandom(94763));
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    chk({30'h0, rdy_n_out, irq_out}, 32'h2);
    rdc(8'h0C, 32'h0, RESP_OKAY);
    rdc(8'h10, 32'h0, RESP_OKAY);
    rdc(8'h20, 32'h0, RESP_OKAY);
    rdc(8'h3C, 32'h0, RESP_SLVERR);
    wr(8'h0C, 32'h0000_1234, RESP_SLVERR);
    // Every protection code, reserved bits kept clear
    for (int m = 0; m < 4; m++) begin
      wr(8'h20, {28'h0, 2'(m), 2'b00}, RESP_OKAY);
      @(negedge mclk_in);
      chk({28'h0, link_prot_out}, {28'h0, prot(2'(m))});
      rdc(8'h20, {28'h0, 2'(m), 2'b00}, RESP_OKAY);
    end
    // Checksum over user registers
    u0 = 24'($urandom());
    u1 = 24'($urandom());
    wr(8'h28, {8'h0, u0}, RESP_OKAY);
    wr(8'h2C, {8'h0, u1}, RESP_OKAY);
    rdc(8'h0C, 32'h0, RESP_OKAY);
    wr(8'h20, 32'h0000_0020, RESP_OKAY);
    rdc(8'h0C, {8'h0, u0 ^ u1}, RESP_OKAY);
    wr(8'h20, 32'h0000_0060, RESP_OKAY);
    raw = 24'($urandom());
    ch = 4'($urandom());
    conv(raw, ch);
    chk({31'h0, rdy_n_out}, 32'h0);
    rdc(8'h24, {28'h0, ch}, RESP_OKAY);
    axil_host_model_i.rd(8'h10, 0, rv, rr);
    chk(rv & 32'hFFFF_FF7F, {code(raw, u0[0]), 4'h0, ch});
    @(negedge mclk_in);
    chk({31'h0, rdy_n_out}, 32'h1);
    wr(8'h20, 32'h0000_0020, RESP_OKAY);
    rdc(8'h10, {8'h0, code(raw, u0[0])}, RESP_OKAY);
    @(negedge mclk_in);
    chk({31'h0, rdy_n_out}, 32'h1);
    u0 = u0 ^ 24'h00_0010;
    wr(8'h28, {8'h0, u0}, RESP_OKAY);
    rdc(8'h24, {24'h0, 4'h9, ch}, RESP_OKAY);
    // Interrupt masked, enabled, cleared
    @(negedge mclk_in);
    chk({31'h0, irq_out}, 32'h0);
    wr(8'h34, 32'h0000_0001, RESP_OKAY);
    @(negedge mclk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(8'h38, 32'h0000_0001, RESP_OKAY);
    rdc(8'h30, 32'h0000_0002, RESP_OKAY);
    @(negedge mclk_in);
    chk({31'h0, irq_out}, 32'h0);
    wr(8'h34, 32'h0000_0002, RESP_OKAY);
    @(negedge mclk_in);
    chk({31'h0, irq_out}, 32'h1);
    wr(8'h20, 32'h0000_0041, RESP_OKAY);
    rdc(8'h0C, 32'h0, RESP_OKAY);
    axil_host_model_i.rd(8'h10, 0, rv, rr);
    chk(rv & 32'hFFFF_FF7F, {code(raw, u0[0]), 4'h0, ch});
    wr(8'h38, 32'h0000_0002, RESP_OKAY);
    @(negedge mclk_in);
    chk({31'h0, irq_out}, 32'h0);
    // Short word with status appended
    raw = 24'($urandom());
    conv(raw, ch);
    axil_host_model_i.rd(8'h10, 0, rv, rr);
    chk(rv & 32'hFFFF_FF7F, {code(raw, u0[0]) >> 8, 4'h0, ch});
    rdc(8'h24, {24'h0, 4'h8, ch}, RESP_OKAY);
    wr(8'h20, 32'h0000_0000, RESP_OKAY);
    // Random results, then one arriving during a pending read
    for (int i = 0; i < 4; i++) begin
      raw = 24'($urandom());
      conv(raw, 4'(i));
      rdc(8'h10, {8'h0, code(raw, u0[0])}, RESP_OKAY);
    end
    held = code(raw, u0[0]);
    fork
      axil_host_model_i.rd(8'h10, 6, rv, rr);
      begin
        repeat (3) @(posedge mclk_in);
        conv(24'($urandom()), 4'h5);
      end
    join
    chk(rv, {8'h0, held});
    rdc(8'h10, {8'h0, held}, RESP_OKAY);
    test_done();
  end
endmodule // adc_result_and_checksum_regs_bench

// [verif/axil_host_model.sv]
`timescale 1ns/1ps
module axil_host_model (
  // Clock
  input  wire logic        clk_in,
  // Write channels
  output logic [7:0]       awaddr_out,
  output logic             awvalid_out,
  input  wire logic        awready_in,
  output logic [31:0]      wdata_out,
  output logic [3:0]       wstrb_out,
  output logic             wvalid_out,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out,
  // Read channels
  output logic [7:0]       araddr_out,
  output logic             arvalid_out,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out,
  // Hang flag
  output logic             hung_out
);
  // Idle master at time zero
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out, hung_out} = '0;
    wstrb_out = 4'hF;
  end

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic tb;
    int n;
    tb = 1'b0;
    n = 0;
    r = 2'b00;
    @(posedge clk_in);
    awaddr_out  <= a;
    wdata_out   <= d;
    awvalid_out <= 1'b1;
    wvalid_out  <= 1'b1;
    bready_out  <= 1'b1;
    // Each pass looks at the values that stood at this rising edge
    while (!tb && n < 60) begin
      @(posedge clk_in);
      n++;
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
      end
      if (bvalid_in && bready_out) begin
        tb = 1'b1;
        r  = bresp_in;
      end
    end
    bready_out <= 1'b0;
    if (!tb) begin
      hung_out <= 1'b1;
    end
  endtask

  // Read: rready may lag by dly cycles to keep the read pending
  task automatic rd(input logic [7:0] a, input int dly, output logic [31:0] d,
                    output logic [1:0] r);
    logic tr;
    int n;
    tr = 1'b0;
    n = 0;
    d = '0;
    r = 2'b00;
    @(posedge clk_in);
    araddr_out  <= a;
    arvalid_out <= 1'b1;
    rready_out  <= (dly == 0);
    // Data is taken at the edge where rvalid and rready both stood high
    while (!tr && n < 60 + dly) begin
      @(posedge clk_in);
      n++;
      if (arvalid_out && arready_in) begin
        arvalid_out <= 1'b0;
      end
      if (rvalid_in && rready_out) begin
        tr = 1'b1;
        d  = rdata_in;
        r  = rresp_in;
      end else if (n >= dly && n < 60 + dly) begin
        rready_out <= 1'b1;
      end
    end
    rready_out <= 1'b0;
    if (!tr) begin
      hung_out <= 1'b1;
    end
  endtask
endmodule // axil_host_model
